// *** src/sfps_top.sv ***
// Partition register and queue status counters of the shared frame buffer
`timescale 1ns/1ps

module sfps_top
    import sfps_pkg::*;
(
    input  wire logic          clock,           // System clock, 250 MHz
    input  wire logic          rst_n,           // Asynchronous reset, active low
    input  wire sfps_reg_req_t reg_req,         // Register port request
    output logic        [31:0] reg_rdata,       // Read data, registered
    output logic               reg_rvalid,      // Read data valid pulse
    input  wire sfps_events_t  events,          // Datapath event pulses
    output sfps_sizes_t        sizes,           // Size codes to the buffer manager
    output logic        [17:0] total_bytes,     // Sum of configured capacities
    output logic               over_budget,     // Total exceeds shared memory
    output logic               reserved_code    // Some field holds a reserved code
);

    typedef struct packed {
        sfps_sizes_t sizes;
        logic [31:0] rdata;
        logic        rvalid;
    } sfps_state_t;

    sfps_state_t                     state;
    sfps_state_t                     next_state;
    logic [SFPS_FRAME_CNT_W-1:0]     frame_count;
    logic [SFPS_HALFWORD_W-1:0]      halfword_count;
    logic [SFPS_DROP_CNT_W-1:0]      drop_count;
    logic [SFPS_FIELDS_W-1:0]        fields;

    ////////////////////////////////////////////////////////////////////////////
    // Status counters
    sfps_counter #(.WIDTH(SFPS_FRAME_CNT_W)) u_frames (
        .clock (clock),
        .rst_n (rst_n),
        .clear (events.switch_queue_clear),
        .inc   (events.xmit_frame_in),
        .dec   (events.xmit_frame_out),
        .count (frame_count)
    );

    sfps_counter #(.WIDTH(SFPS_HALFWORD_W)) u_halfwords (
        .clock (clock),
        .rst_n (rst_n),
        .clear (events.switch_queue_clear),
        .inc   (events.host_halfword_in),
        .dec   (events.host_halfword_out),
        .count (halfword_count)
    );

    // Drop counter is not cleared by the queue clear, only by reset
    sfps_counter #(.WIDTH(SFPS_DROP_CNT_W)) u_drops (
        .clock (clock),
        .rst_n (rst_n),
        .clear (1'b0),
        .inc   (events.host_frame_dropped),
        .dec   (1'b0),
        .count (drop_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register writes and registered read data
    always_comb begin
        next_state        = state;
        next_state.rvalid = reg_req.rd;
        if (reg_req.wr && reg_req.addr == SFPS_OFS_PARTITION) begin
            // Top nibble is dropped on write
            next_state.sizes = sfps_sizes_t'(reg_req.wdata[SFPS_FIELDS_W-1:0]);
        end
        if (reg_req.rd) begin
            if (reg_req.addr == SFPS_OFS_PARTITION) begin
                next_state.rdata = {4'h0, state.sizes};
            end else if (reg_req.addr == SFPS_OFS_FRAMES) begin
                next_state.rdata = {23'h000000, frame_count};
            end else if (reg_req.addr == SFPS_OFS_HALFWORDS) begin
                next_state.rdata = {18'h00000, halfword_count};
            end else if (reg_req.addr == SFPS_OFS_DROPS) begin
                next_state.rdata = drop_count;
            end else begin
                next_state.rdata = 32'h00000000;
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state.sizes  <= sfps_sizes_t'(SFPS_PARTITION_RST[SFPS_FIELDS_W-1:0]);
            state.rdata  <= 32'h00000000;
            state.rvalid <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capacity sum and code checks over the seven fields
    assign fields = state.sizes;

    always_comb begin
        total_bytes   = '0;
        reserved_code = 1'b0;
        for (int i = 0; i < SFPS_NUM_FIFOS; i++) begin
            total_bytes = total_bytes
                        + 18'(sfps_code_bytes(fields[i*SFPS_CODE_W +: SFPS_CODE_W]));
            if (fields[i*SFPS_CODE_W +: SFPS_CODE_W] > SFPS_CODE_MAX) begin
                reserved_code = 1'b1;
            end
        end
    end

    // Flags a budget the software should have avoided
    assign over_budget = total_bytes > SFPS_SHARED_BYTES;

    assign sizes      = state.sizes;
    assign reg_rdata  = state.rdata;
    assign reg_rvalid = state.rvalid;

endmodule

// *** src/sfps_pkg.sv ***
// Package for the switch FIFO partition and status block
package sfps_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register word offsets on the internal register port
    localparam logic [7:0]  SFPS_OFS_PARTITION = 8'h3e;
    localparam logic [7:0]  SFPS_OFS_FRAMES    = 8'h3f;
    localparam logic [7:0]  SFPS_OFS_HALFWORDS = 8'h40;
    localparam logic [7:0]  SFPS_OFS_DROPS     = 8'h41;

    ////////////////////////////////////////////////////////////////////////////
    // Field layout, widths and reset values
    localparam int          SFPS_CODE_W        = 4;
    localparam int          SFPS_NUM_FIFOS     = 7;
    localparam int          SFPS_FIELDS_W      = SFPS_CODE_W * SFPS_NUM_FIFOS;
    localparam int          SFPS_FRAME_CNT_W   = 9;
    localparam int          SFPS_HALFWORD_W    = 14;
    localparam int          SFPS_DROP_CNT_W    = 32;
    localparam logic [31:0] SFPS_PARTITION_RST = 32'h02222222;
    localparam logic [3:0]  SFPS_CODE_MAX      = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // Capacity arithmetic
    localparam int          SFPS_BYTES_W       = 15;
    localparam int          SFPS_TOTAL_W       = 18;
    localparam int          SFPS_SHIFT_2KB     = 11;
    localparam logic [17:0] SFPS_SHARED_BYTES  = 18'h07000;

    // Seven size codes, most significant field first
    typedef struct packed {
        logic [3:0] port1_to_port2_xmit_capacity;
        logic [3:0] port2_to_port1_xmit_capacity;
        logic [3:0] second_port_recv_high_capacity;
        logic [3:0] second_port_recv_low_capacity;
        logic [3:0] first_port_recv_high_capacity;
        logic [3:0] first_port_recv_low_capacity;
        logic [3:0] host_xmit_capacity;
    } sfps_sizes_t;

    // Event pulses from the queue datapath
    typedef struct packed {
        logic xmit_frame_in;
        logic xmit_frame_out;
        logic host_halfword_in;
        logic host_halfword_out;
        logic host_frame_dropped;
        logic switch_queue_clear;
    } sfps_events_t;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic        rd;
        logic [31:0] wdata;
    } sfps_reg_req_t;

    // Bytes held by one size code, zero for reserved codes
    function automatic logic [14:0] sfps_code_bytes(input logic [3:0] code);
        logic [14:0] bytes;
        bytes = '0;
        if (code <= SFPS_CODE_MAX) begin
            bytes = 15'({11'h000, code} << SFPS_SHIFT_2KB);
        end
        return bytes;
    endfunction

endpackage

// *** src/sfps_counter.sv ***
// Up/down occupancy counter with synchronous clear
`timescale 1ns/1ps

module sfps_counter
    import sfps_pkg::*;
#(
    parameter int WIDTH = 9
) (
    input  wire logic             clock,   // System clock
    input  wire logic             rst_n,   // Asynchronous reset, active low
    input  wire logic             clear,   // Synchronous clear to zero
    input  wire logic             inc,     // Count up pulse
    input  wire logic             dec,     // Count down pulse
    output logic      [WIDTH-1:0] count    // Current count
);

    typedef struct packed {
        logic [WIDTH-1:0] value;
    } sfps_cnt_state_t;

    sfps_cnt_state_t state;
    sfps_cnt_state_t next_state;

    ////////////////////////////////////////////////////////////////////////////
    // Next count: clear wins, simultaneous up and down hold
    always_comb begin
        next_state = state;
        if (clear) begin
            next_state.value = '0;
        end else if (inc && !dec) begin
            next_state.value = state.value + WIDTH'(1);
        end else if (dec && !inc) begin
            next_state.value = state.value - WIDTH'(1);
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign count = state.value;

endmodule

// *** sim/sfps_properties.sv ***
// Assertions on the partition register and status ports
`timescale 1ns/1ps

module sfps_properties
    import sfps_pkg::*;
(
    input  wire logic          clock,         // System clock
    input  wire logic          rst_n,         // Reset, active low
    input  wire sfps_reg_req_t reg_req,       // Register request
    input  wire logic   [31:0] reg_rdata,     // Read data
    input  wire logic          reg_rvalid,    // Read valid
    input  wire sfps_events_t  events,        // Event pulses
    input  wire sfps_sizes_t   sizes,         // Size codes
    input  wire logic   [17:0] total_bytes,   // Capacity sum
    input  wire logic          over_budget,   // Over budget flag
    input  wire logic          reserved_code  // Reserved code flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////
    // Decoded register strobes and frame traffic idle condition
    wire wr_part = reg_req.wr && reg_req.addr == SFPS_OFS_PARTITION;
    wire rd_part = reg_req.rd && reg_req.addr == SFPS_OFS_PARTITION;
    wire rd_frames = reg_req.rd && reg_req.addr == SFPS_OFS_FRAMES;
    wire rd_half = reg_req.rd && reg_req.addr == SFPS_OFS_HALFWORDS;
    wire frames_idle = !events.xmit_frame_in && !events.xmit_frame_out;

    ////////////////////////////////////////////////////////////////////////////
    // Reference capacity sum: code times 2 kB, reserved codes count nothing
    function automatic logic [17:0] cap_sum(input logic [27:0] f);
        logic [17:0] sum;
        sum = 18'h00000;
        for (int i = 0; i < 7; i++) begin
            if (f[i*4 +: 4] <= 4'h8) begin
                sum = sum + {3'h0, f[i*4 +: 4], 11'h000};
            end
        end
        return sum;
    endfunction

    // Reference reserved-code detection over the seven fields
    function automatic logic any_reserved(input logic [27:0] f);
        logic hit;
        hit = 1'h0;
        for (int i = 0; i < 7; i++) begin
            if (f[i*4 +: 4] > 4'h8) begin
                hit = 1'h1;
            end
        end
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Read timing, register contents and flags
    read_answer_a: assert property (reg_req.rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    read_quiet_a: assert property (!reg_req.rd |=> !reg_rvalid)
        else $error("read valid without a read");
    size_write_a: assert property (wr_part |=> sizes == $past(reg_req.wdata[27:0]))
        else $error("size write not stored");
    size_hold_a: assert property (!wr_part |=> $stable(sizes))
        else $error("sizes changed without a write");
    size_reset_a: assert property (!$past(rst_n) |-> sizes == 28'h2222222)
        else $error("sizes wrong after reset");
    part_read_a: assert property (rd_part |=> reg_rdata == {4'h0, $past(sizes)})
        else $error("partition read wrong");
    frame_upper_a: assert property (rd_frames |=> reg_rdata[31:9] == '0)
        else $error("frame count upper bits set");
    half_upper_a: assert property (rd_half |=> reg_rdata[31:14] == '0)
        else $error("half-word count upper bits set");
    budget_flag_a: assert property (over_budget == (total_bytes > 18'h07000))
        else $error("budget flag wrong");
    total_sum_a: assert property (total_bytes == cap_sum(sizes))
        else $error("capacity sum wrong");
    reserved_flag_a: assert property (reserved_code == any_reserved(sizes))
        else $error("reserved code flag wrong");
    clear_zero_a: assert property (events.switch_queue_clear ##1 frames_idle
        ##1 rd_frames |=> reg_rdata == 32'h00000000)
        else $error("frame count not zero after clear");
endmodule

bind sfps_top sfps_properties sfps_properties_i (.clock(clock), .rst_n(rst_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .events(events),
    .sizes(sizes), .total_bytes(total_bytes), .over_budget(over_budget),
    .reserved_code(reserved_code));

// *** sim/testbench.sv ***
// Self-checking bench for the partition and status block
`timescale 1ns/1ps

module testbench;
    import sfps_pkg::*;
    typedef struct packed {logic [31:0] w; logic [17:0] tot; logic ovr; logic rsv;} sfps_row_t;
    logic          clock = 1'h0;
    logic          rst_n = 1'h0;
    sfps_reg_req_t req = '0;
    sfps_events_t  ev = '0;
    logic   [31:0] rdata;
    logic          rvalid;
    sfps_sizes_t   sizes;
    logic   [17:0] tot;
    logic          ovr;
    logic          rsv;
    logic   [31:0] d;
    int            n_fail = 0;
    int            n_tests = 0;
    sfps_row_t     rows [7] = '{'{32'h00000000, 18'h00000, 1'h0, 1'h0},
        '{32'h02222222, 18'h07000, 1'h0, 1'h0}, '{32'hf8000000, 18'h04000, 1'h0, 1'h0},
        '{32'h08800000, 18'h08000, 1'h1, 1'h0}, '{32'h01234567, 18'h0e000, 1'h1, 1'h0},
        '{32'h00000009, 18'h00000, 1'h0, 1'h1}, '{32'h0000000f, 18'h00000, 1'h0, 1'h1}};

    // Clock, 4 ns period
    always #2 clock = ~clock;

    sfps_top sfps_top_i (.clock(clock), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .events(ev), .sizes(sizes), .total_bytes(tot),
        .over_budget(ovr), .reserved_code(rsv));

    ////////////////////////////////////////////////////////////////////////////
    // Compare, register access, event pulses and closing report
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] v);
        @(negedge clock);
        req = '{a, w, !w, v};
        @(negedge clock);
        req = '0;
        chk(rvalid, !w);
        d = rdata;
    endtask

    task automatic pulse(input sfps_events_t e, input int n);
        repeat (n) begin
            @(negedge clock);
            ev = e;
        end
        @(negedge clock);
        ev = '0;
    endtask

    task automatic stop_test;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(negedge clock);
        rst_n = 1'h1;
        // Queues cleared and traffic idle before any resize
        pulse(6'h01, 1);
        acc(SFPS_OFS_FRAMES, 1'h0, 32'h0);
        chk(d, 32'h0);
        for (int i = 0; i < 7; i++) begin
            acc(SFPS_OFS_PARTITION, 1'h1, rows[i].w);
            chk(sizes, {4'h0, rows[i].w[27:0]});
            chk({ovr, rsv, 12'h000, tot}, {rows[i].ovr, rows[i].rsv, 12'h000, rows[i].tot});
            acc(SFPS_OFS_PARTITION, 1'h0, 32'h0);
            chk(d, {4'h0, rows[i].w[27:0]});
            $display("row %0d done", i);
        end
        pulse(6'h20, 3);
        pulse(6'h30, 1);
        pulse(6'h10, 1);
        acc(SFPS_OFS_FRAMES, 1'h0, 32'h0);
        chk(d, 32'h2);
        pulse(6'h08, 5);
        pulse(6'h04, 1);
        acc(SFPS_OFS_HALFWORDS, 1'h0, 32'h0);
        chk(d, 32'h4);
        pulse(6'h02, 3);
        pulse(6'h29, 1); // Clear wins over same-cycle increments
        acc(SFPS_OFS_HALFWORDS, 1'h0, 32'h0);
        chk(d, 32'h0);
        acc(SFPS_OFS_DROPS, 1'h0, 32'h0);
        chk(d, 32'h3);
        pulse(6'h10, 1);
        acc(SFPS_OFS_FRAMES, 1'h1, 32'h5);
        acc(SFPS_OFS_FRAMES, 1'h0, 32'h0);
        chk(d, 32'h1ff);
        acc(8'h42, 1'h0, 32'h0);
        chk(d, 32'h0);
        pulse(6'h08, 2);
        acc(SFPS_OFS_HALFWORDS, 1'h0, 32'h0);
        chk(d, 32'h2);
        $display("event and counter test done");
        @(negedge clock);
        rst_n = 1'h0;
        @(negedge clock);
        chk(sizes, 28'h2222222);
        chk(rdata, 32'h0);
        rst_n = 1'h1;
        acc(SFPS_OFS_PARTITION, 1'h0, 32'h0);
        chk(d, 32'h02222222);
        acc(SFPS_OFS_DROPS, 1'h0, 32'h0);
        chk(d, 32'h0);
        acc(SFPS_OFS_FRAMES, 1'h0, 32'h0);
        chk(d, 32'h0);
        acc(SFPS_OFS_HALFWORDS, 1'h0, 32'h0);
        chk(d, 32'h0);
        $display("reset test done");
        stop_test();
    end
endmodule
